//--- dv/ixp_master_bfm.sv
// Serial bus master model: clock line and open-drain data line.
// Assumes link_clk runs at least eight times the bit rate made here.
module ixp_master_bfm (
  // Link clock
  input  wire logic link_clk,
  // Device data pin
  input  wire logic sda_o,
  input  wire logic sda_oe_n,
  // Bus lines
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sda_m = 1'b1;

  // Pulled up: low while either party pulls it, so no stale value shows
  assign sda = sda_m & (sda_oe_n | sda_o);
  // Clock stands high between frames
  initial scl = 1'b1;

  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask

  // Data changes only while the clock is low
  task automatic put_bit(input logic v, output logic r);
    tick(2);
    sda_m = v;
    tick(6);
    scl = 1'b1;
    tick(3);
    r = sda;
    tick(5);
    scl = 1'b0;
  endtask

  // Also a repeated start; waits for the device to let go first
  task automatic start();
    sda_m = 1'b1;
    tick(8);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b0;
    tick(6);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_m = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b1;
    tick(10);
  endtask

  // Address or data byte, MSB first, then the device's answer
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(b[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask

  // Read byte; a low answer asks for more, high ends the read
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(~mack, r);
  endtask
endmodule

//--- dv/testbench.sv
// Self-checking bench for the expander addressing logic, base map, plus
// an alternate-map device strapped to the reserved identification address.
// Assumes the bus master model in its own file; no other parts.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [1:0] hi, mid, lo;
    logic [6:0] addr;
  } ixp_row_t;

  // Arbitrary identity values
  localparam logic [7:0]  MFR  = 8'hC3;
  localparam logic [12:0] PART = 13'h1234;
  localparam logic [2:0]  REV  = 3'h5;
  localparam logic [23:0] ID_W = {MFR, PART, REV};
  localparam ixp_row_t ROWS [5] = '{'{2'h0, 2'h0, 2'h0, 7'h20},
    '{2'h1, 2'h1, 2'h1, 7'h27}, '{2'h0, 2'h2, 2'h0, 7'h10},
    '{2'h3, 2'h3, 2'h3, 7'h5F}, '{2'h3, 2'h1, 2'h3, 7'h77}};

  logic       core_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rstn     = 1'b0;
  logic [1:0] addr_strap_hi, addr_strap_mid, addr_strap_lo;
  logic       scl_i, sda_i, sda_o, sda_oe_n, addr_match, alt_oe_n;
  logic       port_wr_en   = 1'b0;
  logic [7:0] port_wr_data = 8'h3C;
  logic [7:0] port_level, d;
  logic       soft_reset_pulse, ack, seen_rst, seen_match;
  int         err_count = 0;
  int         checks    = 0;

  always #2 core_clk = ~core_clk;
  always #7.5 link_clk = ~link_clk;
  always @(posedge core_clk) if (soft_reset_pulse === 1'b1) seen_rst <= 1'b1;
  always @(posedge link_clk) if (addr_match === 1'b1) seen_match <= 1'b1;

  ixp_expander_addr #(.MFR_ID(MFR), .PART_ID(PART), .DIE_REV(REV)) u_dut (
    .core_clk, .rstn, .addr_strap_hi, .addr_strap_mid, .addr_strap_lo,
    .link_clk, .scl_i, .sda_i, .sda_o, .sda_oe_n, .addr_match,
    .port_wr_en, .port_wr_data, .port_level, .soft_reset_pulse);

  // Reserved strap result: this device must never answer its own address
  ixp_expander_addr #(.ALT_MAP(1'b1)) u_alt (
    .core_clk, .rstn, .addr_strap_hi(2'h3), .addr_strap_mid(2'h0),
    .addr_strap_lo(2'h0), .link_clk, .scl_i, .sda_i, .sda_o(),
    .sda_oe_n(alt_oe_n), .addr_match(), .port_wr_en(1'b0),
    .port_wr_data(8'h00), .port_level(), .soft_reset_pulse());

  ixp_master_bfm u_mst (.link_clk, .sda_o,
    .sda_oe_n(sda_oe_n & alt_oe_n), .scl(scl_i), .sda(sda_i));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    #1 rstn = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 rstn = 1'b1;
    #2100;
  endtask

  // A refused byte ends the frame at once, as the master must
  task automatic probe(input logic [7:0] b, input logic exp);
    seen_match = 1'b0;
    u_mst.start();
    u_mst.wr_byte(b, ack);
    chk(ack, exp);
    u_mst.stop();
  endtask

  // Mode 0 ends with STOP, 1 with repeated START, 2 adds a second byte
  task automatic gc_seq(input logic [7:0] cmd, input logic exp, input int m);
    seen_rst = 1'b0;
    u_mst.start();
    u_mst.wr_byte(8'h00, ack);
    chk(ack, 1'b1);
    u_mst.wr_byte(cmd, ack);
    chk(ack, exp);
    if (m == 2) begin
      u_mst.wr_byte(cmd, ack);
      chk(ack, 1'b0);
    end
    if (m == 1) u_mst.start();
    u_mst.stop();
    #200;
  endtask

  task automatic id_arm(input logic [7:0] tgt, input logic exp);
    u_mst.start();
    u_mst.wr_byte(8'hF8, ack);
    u_mst.wr_byte(tgt, ack);
    chk(ack, exp);
  endtask

  initial begin
    foreach (ROWS[i]) begin
      {addr_strap_hi, addr_strap_mid, addr_strap_lo} =
        {ROWS[i].hi, ROWS[i].mid, ROWS[i].lo};
      do_reset();
      chk(port_level, 8'hFF);
      probe({ROWS[i].addr, 1'b0}, 1'b1);
      chk(seen_match, 1'b1);
      probe({ROWS[i].addr ^ 7'h01, 1'b0}, 1'b0);
    end
    // Straps are held from the first capture
    addr_strap_lo = 2'h2;
    probe(8'hEE, 1'b1);
    probe(8'h01, 1'b0);
    @(posedge core_clk);
    #1 port_wr_en = 1'b1;
    @(posedge core_clk);
    #1 port_wr_en = 1'b0;
    gc_seq(8'h05, 1'b0, 0);
    gc_seq(8'h06, 1'b1, 1);
    chk({seen_rst, port_level[6:0]}, 8'h3C);
    gc_seq(8'h06, 1'b1, 0);
    chk({seen_rst, port_level[6:0]}, 8'hFF);
    gc_seq(8'h06, 1'b1, 2);
    id_arm(8'hF8, 1'b0);
    u_mst.stop();
    id_arm(8'hEC, 1'b0);
    u_mst.stop();
    id_arm(8'hEE, 1'b1);
    u_mst.stop();
    probe(8'hF9, 1'b0);
    id_arm(8'hEF, 1'b1);
    u_mst.start();
    u_mst.wr_byte(8'hF9, ack);
    chk(ack, 1'b1);
    for (int k = 0; k < 4; k++) begin
      u_mst.rd_byte(k != 3, d);
      chk(d, ID_W[23 - 8 * (k % 3) -: 8]);
    end
    u_mst.tick(6);
    chk(sda_oe_n, 1'b1);
    u_mst.stop();
    probe(8'hEE, 1'b1);
    stop_test();
  end

  // Whole run takes about 100 us
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule

//--- hdl/ixp_expander_addr.sv
// Addressing, software reset and identification read of an I/O expander.
// Assumes scl/sda arrive unsynchronised; link_clk oversamples the bus and
// runs well above the serial clock.
//
// Contract
// R1: Slave address derives from three four-level straps, 64 choices.
// R2: Address byte after START; direction one reads, zero writes.
// R3: Base map: rail-only straps give 0100 plus strap bits; table otherwise.
// R4: System must not strap reserved addresses in the alternate map.
// R5: Alternate map has own table; reserved results are never acknowledged.
// R6: General call acknowledged only with write direction.
// R7: After general call, acknowledge the data byte only if reset command.
// R8: Bytes after the first general call byte are not acknowledged.
// R9: STOP after acknowledged reset command restores power-up state.
// R10: Repeated START after the reset command cancels the reset.
// R11: Master treats any non-acknowledge in reset sequence as abort.
// R12: Hardwired 24-bit ID: manufacturer, 13-bit part, 3-bit revision.
// R13: ID address write, then own address byte; only match acknowledges.
// R14: Repeated START with ID read; STOP or other slave cancels it.
// R15: ID sent manufacturer first, revision in third byte low bits.
// R16: Master non-acknowledge ends ID read and frees the slave.
// R17: Continued acknowledges wrap the ID read to the first byte.
// R18: Power-up or software reset sets all port lines high, weak pull-up.
// R19: Straps seen as 2-bit codes, sampled once after reset, held.
module ixp_expander_addr #(
  parameter bit         ALT_MAP = 1'b0,
  parameter logic [7:0]  MFR_ID  = 8'h5A,   // Arbitrary value
  parameter logic [12:0] PART_ID = 13'h0A5C, // Arbitrary value
  parameter logic [2:0]  DIE_REV = 3'h1     // Arbitrary value
) (
  // Core clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Strap codes
  input  wire logic [1:0] addr_strap_hi,
  input  wire logic [1:0] addr_strap_mid,
  input  wire logic [1:0] addr_strap_lo,
  // Serial link
  input  wire logic       link_clk,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  output logic            addr_match,
  // Port state, core domain
  input  wire logic       port_wr_en,
  input  wire logic [7:0] port_wr_data,
  output logic      [7:0] port_level,
  output logic            soft_reset_pulse
);

  // ----------------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------------
  logic [6:0] own_addr;
  logic       addr_ok;
  logic       addr_valid;

  ixp_strap_map #(
    .ALT_MAP (ALT_MAP)
  ) u_strap (
    .core_clk       (core_clk),
    .rstn           (rstn),
    .addr_strap_hi  (addr_strap_hi),
    .addr_strap_mid (addr_strap_mid),
    .addr_strap_lo  (addr_strap_lo),
    .own_addr       (own_addr),
    .addr_ok        (addr_ok),
    .addr_valid     (addr_valid)
  );

  // ----------------------------------------------------------------------
  // Link reset and input synchronisers
  // ----------------------------------------------------------------------
  logic link_rst_s1_reg;
  logic link_rstn;
  logic [1:0] bus_s1_reg;
  logic [1:0] bus_s2_reg;
  logic [1:0] bus_d_reg;
  logic valid_s1_reg;
  logic valid_s2_reg;

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      link_rst_s1_reg <= 1'b0;
      link_rstn       <= 1'b0;
    end else begin
      link_rst_s1_reg <= 1'b1;
      link_rstn       <= link_rst_s1_reg;
    end
  end

  // Idle bus is high, so reset to the idle level
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      bus_s1_reg   <= 2'h3;
      bus_s2_reg   <= 2'h3;
      bus_d_reg    <= 2'h3;
      valid_s1_reg <= 1'b0;
      valid_s2_reg <= 1'b0;
    end else begin
      bus_s1_reg   <= {scl_i, sda_i};
      bus_s2_reg   <= bus_s1_reg;
      bus_d_reg    <= bus_s2_reg;
      valid_s1_reg <= addr_valid;
      valid_s2_reg <= valid_s1_reg;
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl_s    = bus_s2_reg[1];
  assign sda_s    = bus_s2_reg[0];
  assign scl_rise = scl_s && !bus_d_reg[1];
  assign scl_fall = !scl_s && bus_d_reg[1];
  assign start_ev = scl_s && bus_d_reg[1] && !sda_s && bus_d_reg[0];
  assign stop_ev  = scl_s && bus_d_reg[1] && sda_s && !bus_d_reg[0];

  // ----------------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------------
  ixp_pkg::ixp_link_st_t st_reg;
  ixp_pkg::ixp_link_st_t ack_next_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] byte_idx_reg;
  logic       ack_q_reg;
  logic       ack_on_reg;
  logic       drive_low_reg;
  logic       gc_ok_reg;
  logic       id_armed_reg;
  logic       rst_tgl_reg;
  logic       rx_state;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic       own_hit;

  // Own address is quasi-static; the synced flag qualifies it
  assign own_hit  = valid_s2_reg && addr_ok && rx_byte[7:1] == own_addr;
  assign rx_state = st_reg == ixp_pkg::S_RX_ADDR ||
                    st_reg == ixp_pkg::S_RX_GC ||
                    st_reg == ixp_pkg::S_RX_GC_MORE ||
                    st_reg == ixp_pkg::S_RX_ID;
  assign rx_byte  = {shift_reg[6:0], sda_s};
  assign byte_done = rx_state && scl_rise && !start_ev && !stop_ev &&
                     bit_cnt_reg == ixp_pkg::BIT_LAST;

  function automatic logic [7:0] id_byte(input logic [1:0] idx);
    logic [23:0] word;
    word = {MFR_ID, PART_ID, DIE_REV}; // R12
    case (idx)
      2'h0:    id_byte = word[23:16]; // R15
      2'h1:    id_byte = word[15:8];
      default: id_byte = word[7:0];
    endcase
  endfunction

  logic [7:0] id_cur;
  assign id_cur = id_byte(byte_idx_reg);

  // Acknowledge decision and follow-on state for a received byte
  logic                  dec_ack;
  ixp_pkg::ixp_link_st_t dec_next;

  always_comb begin
    dec_ack  = 1'b0;
    dec_next = ixp_pkg::S_IGNORE;
    case (st_reg)
      ixp_pkg::S_RX_ADDR: begin
        if (rx_byte[7:1] == ixp_pkg::GC_ADDR) begin
          dec_ack  = !rx_byte[0]; // R6
          dec_next = ixp_pkg::S_RX_GC;
        end else if (rx_byte[7:1] == ixp_pkg::ID_ADDR) begin
          dec_ack  = !rx_byte[0] || id_armed_reg; // R13 R14
          dec_next = rx_byte[0] ? ixp_pkg::S_TX : ixp_pkg::S_RX_ID;
        end else begin
          dec_ack = own_hit; // R2 R5
        end
      end
      ixp_pkg::S_RX_GC: begin
        dec_ack  = rx_byte == ixp_pkg::GC_RESET_CMD; // R7
        dec_next = ixp_pkg::S_RX_GC_MORE;
      end
      ixp_pkg::S_RX_ID: begin
        dec_ack  = own_hit; // R13
        dec_next = ixp_pkg::S_ID_WAIT;
      end
      default: begin
        dec_ack  = 1'b0; // R8
        dec_next = ixp_pkg::S_IGNORE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      st_reg        <= ixp_pkg::S_IDLE;
      ack_next_reg  <= ixp_pkg::S_IGNORE;
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 8'h00;
      ack_q_reg     <= 1'b0;
      ack_on_reg    <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (start_ev) begin
      st_reg        <= ixp_pkg::S_RX_ADDR;
      bit_cnt_reg   <= 3'h0;
      ack_on_reg    <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (stop_ev) begin
      st_reg        <= ixp_pkg::S_IDLE; // R14
      ack_on_reg    <= 1'b0;
      drive_low_reg <= 1'b0;
    end else begin
      case (st_reg)
        ixp_pkg::S_RX_ADDR, ixp_pkg::S_RX_GC, ixp_pkg::S_RX_GC_MORE,
        ixp_pkg::S_RX_ID: begin
          if (scl_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done) begin
              ack_q_reg    <= dec_ack;
              ack_next_reg <= dec_next;
              st_reg       <= dec_ack ? ixp_pkg::S_ACK : ixp_pkg::S_IGNORE;
            end
          end
        end
        ixp_pkg::S_ACK: begin
          // Pull low from the fall after bit 8 to the fall after the ack
          if (scl_fall && !ack_on_reg) begin
            ack_on_reg    <= 1'b1;
            drive_low_reg <= ack_q_reg;
          end else if (scl_fall) begin
            ack_on_reg  <= 1'b0;
            bit_cnt_reg <= 3'h0;
            st_reg      <= ack_next_reg;
            if (ack_next_reg == ixp_pkg::S_TX) begin
              shift_reg     <= id_cur;
              drive_low_reg <= !id_cur[7];
            end else begin
              drive_low_reg <= 1'b0;
            end
          end
        end
        ixp_pkg::S_TX: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg   <= {shift_reg[6:0], 1'b1};
            if (bit_cnt_reg == ixp_pkg::BIT_LAST) begin
              drive_low_reg <= 1'b0;
              st_reg        <= ixp_pkg::S_TX_ACK;
            end else begin
              drive_low_reg <= !shift_reg[6];
            end
          end
        end
        ixp_pkg::S_TX_ACK: begin
          // Master ack sampled on the rise; next byte starts at the fall
          if (scl_rise) begin
            st_reg <= sda_s ? ixp_pkg::S_IGNORE : ixp_pkg::S_ACK; // R16
            ack_q_reg    <= 1'b0;
            ack_on_reg   <= 1'b1;
            ack_next_reg <= ixp_pkg::S_TX;
          end
        end
        ixp_pkg::S_IDLE, ixp_pkg::S_ID_WAIT, ixp_pkg::S_IGNORE: begin
          drive_low_reg <= 1'b0;
        end
        default: begin
          st_reg <= ixp_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Identification byte pointer and sequence flags
  // ----------------------------------------------------------------------
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      byte_idx_reg <= 2'h0;
    end else if (st_reg != ixp_pkg::S_TX &&
                 st_reg != ixp_pkg::S_TX_ACK && st_reg != ixp_pkg::S_ACK) begin
      byte_idx_reg <= 2'h0;
    end else if (st_reg == ixp_pkg::S_TX_ACK && scl_rise && !sda_s) begin
      byte_idx_reg <= (byte_idx_reg == ixp_pkg::ID_LAST_BYTE) ?
                      2'h0 : byte_idx_reg + 2'h1; // R17
    end
  end

  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      gc_ok_reg <= 1'b0;
    end else if (start_ev || stop_ev) begin
      gc_ok_reg <= 1'b0; // R10
    end else if (byte_done) begin
      gc_ok_reg <= st_reg == ixp_pkg::S_RX_GC && dec_ack; // R7 R8
    end
  end

  // Armed only across a repeated START straight after the target byte
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      id_armed_reg <= 1'b0;
    end else if (start_ev) begin
      id_armed_reg <= st_reg == ixp_pkg::S_ID_WAIT; // R14
    end else if (stop_ev) begin
      id_armed_reg <= 1'b0; // R14
    end else if (byte_done && st_reg == ixp_pkg::S_RX_ID) begin
      id_armed_reg <= dec_ack;
    end else if (st_reg == ixp_pkg::S_TX_ACK && scl_rise && sda_s) begin
      id_armed_reg <= 1'b0; // R16
    end
  end

  // Toggle carries the reset event into the core domain
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      rst_tgl_reg <= 1'b0;
      addr_match  <= 1'b0;
    end else begin
      rst_tgl_reg <= rst_tgl_reg ^ (stop_ev && gc_ok_reg); // R9
      addr_match  <= byte_done && st_reg == ixp_pkg::S_RX_ADDR &&
                     own_hit;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = !drive_low_reg;

  // ----------------------------------------------------------------------
  // Core domain: reset event and port state
  // ----------------------------------------------------------------------
  logic [2:0] tgl_sync_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tgl_sync_reg     <= 3'h0;
      soft_reset_pulse <= 1'b0;
    end else begin
      tgl_sync_reg     <= {tgl_sync_reg[1:0], rst_tgl_reg};
      soft_reset_pulse <= tgl_sync_reg[2] ^ tgl_sync_reg[1];
    end
  end

  // High level with only the weak pull-up lets every line act as input
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      port_level <= ixp_pkg::PORT_RESET_VAL; // R18
    end else if (soft_reset_pulse) begin
      port_level <= ixp_pkg::PORT_RESET_VAL; // R18
    end else if (port_wr_en) begin
      port_level <= port_wr_data;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_gc_byte;
    byte_done && st_reg == ixp_pkg::S_RX_GC;
  endsequence

  sequence s_master_ack;
    scl_rise && st_reg == ixp_pkg::S_TX_ACK && !sda_s && !start_ev &&
    !stop_ev;
  endsequence

  AST_GC_READ_NACK: assert property ( // R6
    @(posedge link_clk) disable iff (!link_rstn)
    byte_done && st_reg == ixp_pkg::S_RX_ADDR && rx_byte == 8'h01
    |=> st_reg == ixp_pkg::S_IGNORE && sda_oe_n)
    else $error("general call read was acknowledged");

  AST_GC_CMD_ACK: assert property ( // R7
    @(posedge link_clk) disable iff (!link_rstn)
    s_gc_byte ##0 rx_byte == ixp_pkg::GC_RESET_CMD
    |=> st_reg == ixp_pkg::S_ACK && ack_q_reg && gc_ok_reg)
    else $error("reset command not acknowledged");

  AST_GC_BAD_NACK: assert property ( // R7
    @(posedge link_clk) disable iff (!link_rstn)
    s_gc_byte ##0 rx_byte != ixp_pkg::GC_RESET_CMD
    |=> st_reg == ixp_pkg::S_IGNORE && !gc_ok_reg)
    else $error("wrong general call byte acknowledged");

  AST_GC_EXTRA_NACK: assert property ( // R8
    @(posedge link_clk) disable iff (!link_rstn)
    byte_done && st_reg == ixp_pkg::S_RX_GC_MORE
    |=> !gc_ok_reg && st_reg == ixp_pkg::S_IGNORE)
    else $error("extra general call byte acknowledged");

  AST_SOFT_RESET_TGL: assert property ( // R9
    @(posedge link_clk) disable iff (!link_rstn)
    stop_ev && gc_ok_reg |=> rst_tgl_reg != $past(rst_tgl_reg))
    else $error("stop after reset command gave no reset");

  AST_RESTART_CANCEL: assert property ( // R10
    @(posedge link_clk) disable iff (!link_rstn)
    start_ev |=> !gc_ok_reg && rst_tgl_reg == $past(rst_tgl_reg))
    else $error("repeated start did not cancel reset");

  AST_ID_WRAP: assert property ( // R17
    @(posedge link_clk) disable iff (!link_rstn)
    s_master_ack ##0 byte_idx_reg == ixp_pkg::ID_LAST_BYTE
    |=> byte_idx_reg == 2'h0 && st_reg == ixp_pkg::S_ACK)
    else $error("identification read did not wrap");

  AST_ID_NACK_END: assert property ( // R16
    @(posedge link_clk) disable iff (!link_rstn)
    scl_rise && st_reg == ixp_pkg::S_TX_ACK && sda_s && !stop_ev
    |=> st_reg == ixp_pkg::S_IGNORE && !id_armed_reg ##1 sda_oe_n)
    else $error("master nack did not end identification read");

  AST_STOP_CANCEL_ID: assert property ( // R14
    @(posedge link_clk) disable iff (!link_rstn)
    stop_ev |=> !id_armed_reg && st_reg == ixp_pkg::S_IDLE)
    else $error("stop left identification read armed");

  AST_RESERVED_NO_ACK: assert property ( // R5
    @(posedge core_clk) disable iff (!rstn)
    addr_valid && ALT_MAP && (own_addr == ixp_pkg::GC_ADDR ||
                              own_addr == ixp_pkg::ID_ADDR) |-> !addr_ok)
    else $error("reserved strap address enabled");

  AST_PORT_RESET: assert property ( // R18
    @(posedge core_clk) disable iff (!rstn)
    tgl_sync_reg[2] != tgl_sync_reg[1]
    |=> soft_reset_pulse ##1 port_level == ixp_pkg::PORT_RESET_VAL)
    else $error("software reset did not restore port lines");

endmodule

//--- hdl/ixp_pkg.sv
// Constants, state type and address map for the expander's addressing logic.
// Assumes a 250 MHz core clock; the strap codes come from a four-level
// pad sensor outside this logic.
package ixp_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CORE_CLK_PERIOD_PS = 4000;
  localparam int STRAP_SETTLE_NS    = 1000;
  localparam int STRAP_SETTLE_CYC   =
    (STRAP_SETTLE_NS * 1000 + CORE_CLK_PERIOD_PS - 1) / CORE_CLK_PERIOD_PS;

  // ----------------------------------------------------------------------
  // Bus addresses, commands and reset values
  // ----------------------------------------------------------------------
  localparam logic [6:0] GC_ADDR        = 7'h00;
  localparam logic [6:0] ID_ADDR        = 7'h7C;
  localparam logic [7:0] GC_RESET_CMD   = 8'h06;
  localparam logic [7:0] PORT_RESET_VAL = 8'hFF;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [1:0] ID_LAST_BYTE   = 2'h2;

  // ----------------------------------------------------------------------
  // Strap codes: bit 1 marks a bus-line tie, bit 0 the high level
  // ----------------------------------------------------------------------
  localparam logic [1:0] STRAP_VSS = 2'h0;
  localparam logic [1:0] STRAP_VDD = 2'h1;
  localparam logic [1:0] STRAP_SCL = 2'h2;
  localparam logic [1:0] STRAP_SDA = 2'h3;

  // Upper address bits per pattern of bus-tied straps {hi,mid,lo}
  localparam logic [7:0][6:0] BASE_PFX =
    {7'h58, 7'h50, 7'h70, 7'h60, 7'h18, 7'h10, 7'h28, 7'h20};
  localparam logic [7:0][6:0] ALT_PFX =
    {7'h68, 7'h48, 7'h00, 7'h78, 7'h30, 7'h08, 7'h40, 7'h38};

  typedef enum logic [3:0] {
    S_IDLE, S_RX_ADDR, S_RX_GC, S_RX_GC_MORE, S_RX_ID,
    S_ID_WAIT, S_ACK, S_TX, S_TX_ACK, S_IGNORE
  } ixp_link_st_t;

  function automatic logic [6:0] map_addr(input logic       alt,
                                          input logic [1:0] hi,
                                          input logic [1:0] mid,
                                          input logic [1:0] lo);
    logic [2:0] pat;
    pat = {hi[1], mid[1], lo[1]};
    map_addr = (alt ? ALT_PFX[pat] : BASE_PFX[pat]) |
               {4'h0, hi[0], mid[0], lo[0]};
  endfunction

endpackage

//--- hdl/ixp_strap_map.sv
// Strap sampler and slave address lookup, core clock domain.
// Assumes the strap codes are static while the device runs; they are
// synchronised, allowed to settle and then captured once.
module ixp_strap_map #(
  parameter bit ALT_MAP = 1'b0
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Strap codes from the pads
  input  wire logic [1:0] addr_strap_hi,
  input  wire logic [1:0] addr_strap_mid,
  input  wire logic [1:0] addr_strap_lo,
  // Decoded address
  output logic      [6:0] own_addr,
  output logic            addr_ok,
  output logic            addr_valid
);

  localparam int CW = $clog2(ixp_pkg::STRAP_SETTLE_CYC + 1);
  localparam logic [CW-1:0] SETTLE_LAST =
    CW'(ixp_pkg::STRAP_SETTLE_CYC - 1);

  logic [5:0]    strap_s1_reg;
  logic [5:0]    strap_s2_reg;
  logic [CW-1:0] settle_cnt_reg;
  logic [6:0]    addr_next;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strap_s1_reg <= 6'h00;
      strap_s2_reg <= 6'h00;
    end else begin
      strap_s1_reg <= {addr_strap_hi, addr_strap_mid, addr_strap_lo};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  assign addr_next = ixp_pkg::map_addr(ALT_MAP, strap_s2_reg[5:4],
                                       strap_s2_reg[3:2],
                                       strap_s2_reg[1:0]);

  // Captured once after the settle time, then held for comparison
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      settle_cnt_reg <= '0;
      own_addr       <= 7'h00;
      addr_ok        <= 1'b0;
      addr_valid     <= 1'b0;
    end else if (!addr_valid) begin
      settle_cnt_reg <= settle_cnt_reg + CW'(1);
      if (settle_cnt_reg == SETTLE_LAST) begin // R19
        own_addr   <= addr_next; // R1 R3
        // Reserved results never answer // R5
        addr_ok    <= ALT_MAP ? (addr_next != ixp_pkg::GC_ADDR &&
                                 addr_next != ixp_pkg::ID_ADDR) : 1'b1;
        addr_valid <= 1'b1;
      end
    end
  end

endmodule
